// file: logic/acs_top.sv
// channel sequencer, conversion control and register slave
`timescale 1ns/1ps
module acs_top #(
  parameter int WIDTH = 12
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [3:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [3:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             conversion_start_n,
  input  wire logic             conversion_clock_in,
  input  wire logic             comparator_high,
  output logic [1:0]            vin_pos_sel,
  output logic [2:0]            vin_neg_sel,
  output logic                  sample_switch_closed,
  output logic                  comparator_balance_switch,
  output logic                  range_double,
  output logic                  coding_twos,
  output logic                  reference_internal,
  output logic [1:0]            power_state,
  output logic [WIDTH-1:0]      dac_code,
  output logic [WIDTH-1:0]      result_data,
  output logic                  result_valid
);
  localparam int CTRL_BITS = acs_pkg::CTRL_W;

  // register slave state
  logic                       aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [3:0]                 awaddr_r, awaddr_nxt;
  logic [31:0]                wdata_r, wdata_nxt;
  logic [3:0]                 wstrb_r, wstrb_nxt;
  logic                       bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]                 bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0]                rdata_r, rdata_nxt;
  logic [CTRL_BITS-1:0]       ctrl_r, ctrl_nxt;
  logic                       ctrl_wr;

  // conversion state
  acs_pkg::acs_conv_type      cs_r, cs_nxt;
  acs_pkg::acs_pwr_type       pwr_r, pwr_nxt;
  logic                       cs_q_r, ck_q_r;
  logic [3:0]                 fall_cnt_r, fall_cnt_nxt;
  logic [2:0]                 seq_ch_r, seq_ch_nxt;
  logic [1:0]                 pos_r, pos_nxt;
  logic [2:0]                 neg_r, neg_nxt;
  logic                       unsafe_r, unsafe_nxt, undef_r, undef_nxt;
  logic                       abort_r, abort_nxt, done_r, done_nxt;
  logic                       cs_fall, cs_rise, ck_fall, start, sar_step, finish;
  logic                       seq_on, diff_in, reserved_in;
  logic [1:0]                 addr_bits, pm_bits, sel_ch;
  logic [2:0]                 seq_next;

  assign seq_on      = ctrl_r[acs_pkg::SEQUENCE_CONTROL_BIT1_POS] & ctrl_r[acs_pkg::SEQUENCE_CONTROL_BIT0_POS];
  assign diff_in     = ctrl_r[acs_pkg::INPUT_TYPE_BIT1_POS] ^ ctrl_r[acs_pkg::INPUT_TYPE_BIT0_POS];
  // reserved input type falls back to ground
  assign reserved_in = ctrl_r[acs_pkg::INPUT_TYPE_BIT1_POS] & ctrl_r[acs_pkg::INPUT_TYPE_BIT0_POS];
  assign addr_bits   = {ctrl_r[acs_pkg::CHANNEL_ADDRESS_BIT1_POS], ctrl_r[acs_pkg::CHANNEL_ADDRESS_BIT0_POS]};
  assign pm_bits     = {ctrl_r[acs_pkg::PM1_POS], ctrl_r[acs_pkg::PM0_POS]};
  assign cs_fall     = cs_q_r & ~conversion_start_n;
  assign cs_rise     = ~cs_q_r & conversion_start_n;
  assign ck_fall     = ck_q_r & ~conversion_clock_in;
  // starts are ignored in full shutdown so the host cannot wake it by accident
  assign start       = cs_fall && (pm_bits != 2'b11);
  // sar steps on the first twelve periods
  assign sar_step    = (cs_r == acs_pkg::CS_CONV) && ck_fall
                       && (fall_cnt_r < acs_pkg::SAR_STEPS);
  assign finish      = (cs_r == acs_pkg::CS_CONV) && ck_fall
                       && (fall_cnt_r == acs_pkg::CONV_PERIODS - 4'h1);
  // address is channel or sequence end
  assign sel_ch      = seq_on ? seq_ch_r[1:0] : addr_bits;

  always_comb
  begin
    seq_next = seq_ch_r + (diff_in ? 3'h2 : 3'h1);
    if (seq_next > {1'b0, addr_bits})
    begin
      seq_next = 3'h0;
    end
  end

  // register slave next values
  always_comb
  begin
    aw_have_nxt = aw_have_r;
    w_have_nxt  = w_have_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    ctrl_nxt    = ctrl_r;
    ctrl_wr     = 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    if (aw_have_r && w_have_r)
    begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = acs_pkg::RESP_SLVERR;
      if (awaddr_r == acs_pkg::ADDR_CTRL)
      begin
        bresp_nxt = acs_pkg::RESP_OKAY;
        ctrl_wr   = 1'b1;
        if (wstrb_r[0])
        begin
          ctrl_nxt[7:0] = wdata_r[7:0];
        end
        if (wstrb_r[1])
        begin
          ctrl_nxt[CTRL_BITS-1:8] = wdata_r[CTRL_BITS-1:8];
        end
      end
    end
    else if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = acs_pkg::RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      if (s_axi_araddr == acs_pkg::ADDR_CTRL)
      begin
        rdata_nxt[CTRL_BITS-1:0] = ctrl_r;
      end
      else if (s_axi_araddr == acs_pkg::ADDR_STATUS)
      begin
        rdata_nxt[acs_pkg::ST_BUSY_POS]   = (cs_r == acs_pkg::CS_CONV);
        rdata_nxt[acs_pkg::ST_UNSAFE_POS] = unsafe_r;
        rdata_nxt[acs_pkg::ST_UNDEF_POS]  = undef_r;
        rdata_nxt[acs_pkg::ST_ABORT_POS]  = abort_r;
        rdata_nxt[acs_pkg::ST_CH_POS+:2]  = pos_r;
        rdata_nxt[acs_pkg::ST_PWR_POS+:2] = pwr_r;
      end
      else if (s_axi_araddr == acs_pkg::ADDR_RESULT)
      begin
        rdata_nxt[WIDTH-1:0] = result_data;
      end
      else
      begin
        rresp_nxt = acs_pkg::RESP_SLVERR;
      end
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= 4'h0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
      rvalid_r  <= 1'b0;
      rresp_r   <= 2'h0;
      rdata_r   <= 32'h0000_0000;
      ctrl_r    <= acs_pkg::CTRL_RESET;
    end
    else
    begin
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
      ctrl_r    <= ctrl_nxt;
    end
  end

  assign s_axi_awready = ~aw_have_r & ~bvalid_r;
  assign s_axi_wready  = ~w_have_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  // conversion and sequencer next values
  always_comb
  begin
    cs_nxt       = cs_r;
    pwr_nxt      = pwr_r;
    fall_cnt_nxt = fall_cnt_r;
    seq_ch_nxt   = seq_ch_r;
    pos_nxt      = pos_r;
    neg_nxt      = neg_r;
    unsafe_nxt   = unsafe_r;
    undef_nxt    = undef_r;
    abort_nxt    = abort_r;
    done_nxt     = 1'b0;
    if (cs_r == acs_pkg::CS_IDLE)
    begin
      pos_nxt = sel_ch;
      neg_nxt = acs_pkg::NEG_GROUND;
      // pair partner is address xor 1
      if (diff_in)
      begin
        neg_nxt = {1'b0, sel_ch ^ 2'b01};
      end
    end
    if (ck_fall && (cs_r == acs_pkg::CS_CONV))
    begin
      fall_cnt_nxt = fall_cnt_r + 4'h1;
    end
    if (finish)
    begin
      cs_nxt   = acs_pkg::CS_IDLE;
      done_nxt = 1'b1;
    end
    // start rise or clock fall restores safety
    if (cs_rise || ck_fall)
    begin
      unsafe_nxt = 1'b0;
    end
    if (start)
    begin
      if ((cs_r == acs_pkg::CS_CONV) && !finish)
      begin
        abort_nxt = 1'b1;
        // past twelve and a half periods
        if ((fall_cnt_r == acs_pkg::SAR_STEPS) && ck_q_r && !ck_fall)
        begin
          unsafe_nxt = 1'b1;
        end
      end
      cs_nxt       = acs_pkg::CS_CONV;
      fall_cnt_nxt = 4'h0;
      pwr_nxt      = acs_pkg::PWR_ON;
      if (seq_on)
      begin
        seq_ch_nxt = seq_next;
      end
    end
    if (finish && (pm_bits == 2'b01))
    begin
      pwr_nxt = acs_pkg::PWR_SHUT;
    end
    else if (finish && (pm_bits == 2'b10))
    begin
      pwr_nxt = acs_pkg::PWR_STBY;
    end
    // full shutdown keeps the control register
    if (pm_bits == 2'b11)
    begin
      pwr_nxt = acs_pkg::PWR_SHUT;
    end
    if (ctrl_wr)
    begin
      seq_ch_nxt = 3'h0;
      // an abort in the same cycle wins over the clear
      if (!(start && (cs_r == acs_pkg::CS_CONV) && !finish))
      begin
        abort_nxt = 1'b0;
      end
      undef_nxt  = unsafe_r;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cs_r       <= acs_pkg::CS_IDLE;
      pwr_r      <= acs_pkg::PWR_ON;
      cs_q_r     <= 1'b1;
      ck_q_r     <= 1'b0;
      fall_cnt_r <= 4'h0;
      seq_ch_r   <= 3'h0;
      pos_r      <= 2'h0;
      neg_r      <= acs_pkg::NEG_GROUND;
      unsafe_r   <= 1'b0;
      undef_r    <= 1'b0;
      abort_r    <= 1'b0;
      done_r     <= 1'b0;
    end
    else
    begin
      cs_r       <= cs_nxt;
      pwr_r      <= pwr_nxt;
      cs_q_r     <= conversion_start_n;
      ck_q_r     <= conversion_clock_in;
      fall_cnt_r <= fall_cnt_nxt;
      seq_ch_r   <= seq_ch_nxt;
      pos_r      <= pos_nxt;
      neg_r      <= neg_nxt;
      unsafe_r   <= unsafe_nxt;
      undef_r    <= undef_nxt;
      abort_r    <= abort_nxt;
      done_r     <= done_nxt;
    end
  end

  acs_sar #(
    .WIDTH           (WIDTH)
  ) u_sar (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .start           (start),
    .step            (sar_step),
    .finish          (finish),
    .comparator_high (comparator_high),
    .coding_twos     (coding_twos),
    .dac_code        (dac_code),
    .result_data     (result_data)
  );

  assign vin_pos_sel               = pos_r;
  assign vin_neg_sel               = neg_r;
  assign sample_switch_closed      = (cs_r == acs_pkg::CS_IDLE);
  assign comparator_balance_switch = (cs_r == acs_pkg::CS_IDLE);
  assign range_double              = ctrl_r[acs_pkg::RANGE_POS];
  assign coding_twos               = ctrl_r[acs_pkg::CODING_POS];
  assign reference_internal        = ctrl_r[acs_pkg::REF_POS];
  assign power_state               = pwr_r;
  assign result_valid              = done_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  open_on_start_a: assert property (start |=> !comparator_balance_switch)
    else $error("switches not opened at conversion start");
  single_map_a: assert property (cs_r == acs_pkg::CS_IDLE && !seq_on && !diff_in
    && !reserved_in |=> vin_pos_sel == $past(addr_bits) && vin_neg_sel == 3'h4)
    else $error("single ended selection wrong");
  full_diff_map_a: assert property (cs_r == acs_pkg::CS_IDLE && !seq_on
    && ctrl_r[4:3] == 2'b10 |=> vin_neg_sel == {1'b0, $past(addr_bits) ^ 2'b01})
    else $error("fully differential pair wrong");
  pseudo_map_a: assert property (cs_r == acs_pkg::CS_IDLE && !seq_on
    && ctrl_r[4:3] == 2'b01 |=> vin_neg_sel == {1'b0, $past(addr_bits) ^ 2'b01})
    else $error("pseudo differential pair wrong");
  seq_forward_a: assert property (seq_on && diff_in && !ctrl_wr && !$past(ctrl_wr)
    |-> seq_ch_r[0] == 1'b0)
    else $error("inverse pair reached in sequence");
  done_at_thirteen_a: assert property (cs_r == acs_pkg::CS_CONV && ck_fall
    && fall_cnt_r == 4'hC && !start |=> result_valid ##1 !result_valid)
    else $error("conversion end not at thirteenth period");
  short_abort_a: assert property (start && cs_r == acs_pkg::CS_CONV && !finish
    |=> !result_valid && abort_r)
    else $error("short conversion not aborted");
  reprog_track_a: assert property (ctrl_wr && unsafe_r |=> undef_r)
    else $error("unsafe reprogram not flagged");
  auto_shut_a: assert property (finish && pm_bits == 2'b01 && !start
    |=> power_state == acs_pkg::PWR_SHUT)
    else $error("no shutdown after conversion");
  cover_done_c: cover property (start ##[1:600] result_valid);
  cover_seq_wrap_c: cover property (seq_on && start && seq_next == 3'h0);
  cover_unsafe_c: cover property (ctrl_wr && unsafe_r);
endmodule : acs_top

// file: common/acs_pkg.sv
// package: constants and types of the channel sequencer
// Functional notes
// - both input-type bits 0: positive input per address, negative to ground
// - fully differential: addresses select pairs 0/1, 1/0, 2/3, 3/2
// - pseudo differential uses the same pair mapping as fully differential
// - sequencer off: each conversion uses address of the latest control write
// - sequence-control 11: convert channels 0 up to final address continuously
// - in sequence mode with differential inputs, skip inverse pairs
// - in sequence mode advance channel on each conversion start falling edge
// - a conversion takes 13 complete conversion clock periods from the host
// - abort the conversion when fewer than 13 clock periods arrive
// - track reprogramming while that precondition is unmet; sequencer undefined
// - range bit selects span of reference or twice reference
// - coding bit selects straight binary or twos complement results
// - coding 0 gives straight binary, coding 1 gives twos complement
// - power mode is taken from the two power select bits
// - 00 on, 01 shutdown after conversion, 10 standby after, 11 full shutdown
// - switches closed in acquisition, opened for the whole conversion
// - successive approximation logic makes the code, ends when rebalanced
// - address bits: next channel without sequencer, final channel with it
package acs_pkg;
  localparam logic [3:0]  ADDR_CTRL      = 4'h0;
  localparam logic [3:0]  ADDR_STATUS    = 4'h4;
  localparam logic [3:0]  ADDR_RESULT    = 4'h8;
  localparam logic [11:0] CTRL_RESET     = 12'h000;
  localparam int          CTRL_W         = 12;
  localparam int          RANGE_POS      = 0;
  localparam int          SEQUENCE_CONTROL_BIT0_POS       = 1;
  localparam int          SEQUENCE_CONTROL_BIT1_POS       = 2;
  localparam int          INPUT_TYPE_BIT0_POS      = 3;
  localparam int          INPUT_TYPE_BIT1_POS      = 4;
  localparam int          CHANNEL_ADDRESS_BIT0_POS       = 5;
  localparam int          CHANNEL_ADDRESS_BIT1_POS       = 6;
  localparam int          REF_POS        = 8;
  localparam int          CODING_POS     = 9;
  localparam int          PM0_POS        = 10;
  localparam int          PM1_POS        = 11;
  localparam int          ST_BUSY_POS    = 0;
  localparam int          ST_UNSAFE_POS  = 1;
  localparam int          ST_UNDEF_POS   = 2;
  localparam int          ST_ABORT_POS   = 3;
  localparam int          ST_CH_POS      = 4;
  localparam int          ST_PWR_POS     = 6;
  localparam logic [3:0]  CONV_PERIODS   = 4'hD;
  localparam logic [3:0]  SAR_STEPS      = 4'hC;
  localparam logic [2:0]  NEG_GROUND     = 3'h4;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  typedef enum logic [0:0] {CS_IDLE = 1'b0, CS_CONV = 1'b1} acs_conv_type;
  typedef enum logic [1:0] {
    PWR_ON    = 2'b00,
    PWR_STBY  = 2'b01,
    PWR_SHUT  = 2'b10
  } acs_pwr_type;
endpackage : acs_pkg

// file: logic/acs_sar.sv
// successive approximation register with result coding
`timescale 1ns/1ps
module acs_sar #(
  parameter int WIDTH = 12
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             start,
  input  wire logic             step,
  input  wire logic             finish,
  input  wire logic             comparator_high,
  input  wire logic             coding_twos,
  output logic [WIDTH-1:0]      dac_code,
  output logic [WIDTH-1:0]      result_data
);
  logic [WIDTH-1:0] code_r, code_nxt, mask_r, mask_nxt, res_r, res_nxt;

  always_comb
  begin
    code_nxt = code_r;
    mask_nxt = mask_r;
    res_nxt  = res_r;
    if (start)
    begin
      code_nxt = {1'b1, {(WIDTH-1){1'b0}}};
      mask_nxt = {1'b1, {(WIDTH-1){1'b0}}};
    end
    else if (step && (mask_r != '0))
    begin
      code_nxt = (comparator_high ? code_r : (code_r & ~mask_r)) | (mask_r >> 1);
      mask_nxt = mask_r >> 1;
    end
    if (finish)
    begin
      res_nxt = coding_twos ? {~code_r[WIDTH-1], code_r[WIDTH-2:0]} : code_r;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      code_r <= '0;
      mask_r <= '0;
      res_r  <= '0;
    end
    else
    begin
      code_r <= code_nxt;
      mask_r <= mask_nxt;
      res_r  <= res_nxt;
    end
  end

  assign dac_code    = code_r;
  assign result_data = res_r;
endmodule : acs_sar

// file: tb/acs_host_model.sv
// host side model: conversion start, conversion clock and analog comparator
`timescale 1ns/1ps
module acs_host_model #(
  parameter logic [11:0] LEVEL = 12'hA5C
) (
  input  wire logic        aclk,
  input  wire logic [11:0] dac_code,
  output logic             conversion_start_n,
  output logic             conversion_clock_in,
  output logic             comparator_high
);
  // input held above every trial code up to the sampled level
  assign comparator_high = (dac_code <= LEVEL);

  initial
  begin
    conversion_start_n  = 1'b1;
    conversion_clock_in = 1'b0;
  end

  // start rises after every frame, so a short frame never hides the falling edge of a later start
  task automatic convert(input int falls);
    int i;
    @(posedge aclk);
    conversion_start_n <= 1'b0;
    for (i = 0; i < falls; i++)
    begin
      repeat (2) @(posedge aclk);
      conversion_clock_in <= 1'b1;
      repeat (2) @(posedge aclk);
      conversion_clock_in <= 1'b0;
    end
    @(posedge aclk);
    conversion_start_n <= 1'b1;
  endtask : convert
endmodule : acs_host_model

// file: tb/adc_channel_sequencer_tb_top.sv
// self-checking bench: register bus, input selection, sequencer, conversions
`timescale 1ns/1ps
module adc_channel_sequencer_tb_top;
  localparam logic [11:0] LEVEL = 12'hA5C;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  awaddr = 4'h0;
  logic        awvalid = 1'b0;
  logic        awready;
  logic        wready_w;
  logic [31:0] wdata = 32'h0;
  logic        wvalid = 1'b0;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [3:0]  araddr = 4'h0;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  logic        start_n;
  logic        clk_in;
  logic        cmp_high;
  logic [1:0]  vin_pos_sel;
  logic [2:0]  vin_neg_sel;
  logic        sw_closed;
  logic        bal_sw;
  logic        range_double;
  logic        coding_twos;
  logic        ref_int;
  logic [1:0]  power_state;
  logic [11:0] dac_code;
  logic [11:0] result_data;
  logic        result_valid;
  int          errors = 0;
  int          compares = 0;
  int          cycles = 0;
  int          results = 0;
  logic [31:0] d;
  logic [1:0]  r;
  int          m;
  int          a;
  int          i;
  int          r0;

  always #25 aclk = ~aclk;

  acs_top i_acs_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready_w),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conversion_start_n(start_n), .conversion_clock_in(clk_in), .comparator_high(cmp_high),
    .vin_pos_sel(vin_pos_sel), .vin_neg_sel(vin_neg_sel), .sample_switch_closed(sw_closed),
    .comparator_balance_switch(bal_sw), .range_double(range_double),
    .coding_twos(coding_twos), .reference_internal(ref_int), .power_state(power_state),
    .dac_code(dac_code), .result_data(result_data), .result_valid(result_valid)
  );

  acs_host_model #(.LEVEL(LEVEL)) i_acs_host_model (
    .aclk(aclk), .dac_code(dac_code), .conversion_start_n(start_n),
    .conversion_clock_in(clk_in), .comparator_high(cmp_high)
  );

  always @(posedge aclk)
  begin
    if (result_valid === 1'b1)
      results++;
    cycles++;
    // limit lies far above the fifteen conversions plus register traffic of the test
    if (cycles == 20000)
    begin
      errors++;
      $display("BAD %0t timeout", $time);
      stop_test();
    end
  end

  task automatic stop_test();
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] ad, input logic [31:0] dt, output logic [1:0] rs);
    bit aw_done;
    bit w_done;
    aw_done = 0;
    w_done = 0;
    awaddr <= ad;
    awvalid <= 1'b1;
    wdata <= dt;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1)
      begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready_w === 1'b1)
      begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    dt = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic conv(input int falls);
    fork
      i_acs_host_model.convert(falls);
      begin
        repeat (8) @(posedge aclk);
        #1;
        chk(sw_closed, 1'b0);
        chk(bal_sw, 1'b0);
      end
    join
    repeat (3) @(posedge aclk);
  endtask : conv

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk(vin_neg_sel, acs_pkg::NEG_GROUND);
    chk(sw_closed, 1'b1);
    rd(acs_pkg::ADDR_CTRL, d, r);
    chk(d[11:0], acs_pkg::CTRL_RESET);
    // the loop writes only defined input types and sequencer settings
    for (m = 0; m < 3; m++)
      for (a = 0; a < 4; a++)
      begin
        wr(acs_pkg::ADDR_CTRL, (m << 3) | (a << 5), r);
        repeat (3) @(posedge aclk);
        chk(vin_pos_sel, a);
        chk(vin_neg_sel, (m == 0) ? 4 : (a ^ 1));
      end
    wr(acs_pkg::ADDR_CTRL, 32'h0000007F, r);
    rd(acs_pkg::ADDR_CTRL, d, r);
    chk(d[11:0], 12'h07F);
    // single channel: straight coding, double range, no advance after conversion
    wr(acs_pkg::ADDR_CTRL, 32'h00000061, r);
    conv(13);
    chk(range_double, 1'b1);
    chk(result_data, LEVEL);
    chk(vin_pos_sel, 2'h3);
    wr(acs_pkg::ADDR_CTRL, 32'h00000300, r);
    conv(13);
    chk(coding_twos, 1'b1);
    chk(ref_int, 1'b1);
    chk(result_data, LEVEL ^ 12'h800);
    rd(acs_pkg::ADDR_RESULT, d, r);
    chk(d[11:0], LEVEL ^ 12'h800);
    // sequencer, single ended, final channel 2, wraps to 0
    wr(acs_pkg::ADDR_CTRL, 32'h00000046, r);
    for (i = 0; i < 4; i++)
    begin
      repeat (2) @(posedge aclk);
      chk(vin_pos_sel, i % 3);
      conv(13);
    end
    // sequencer, fully differential, final 3: forward pairs only
    wr(acs_pkg::ADDR_CTRL, 32'h00000076, r);
    for (i = 0; i < 3; i++)
    begin
      repeat (2) @(posedge aclk);
      chk(vin_pos_sel, (i % 2) * 2);
      chk(vin_neg_sel, (i % 2) * 2 + 1);
      conv(13);
    end
    // short frame: no result, next start aborts it
    wr(acs_pkg::ADDR_CTRL, 32'h00000000, r);
    r0 = results;
    conv(12);
    chk(results, r0);
    conv(13);
    chk(results, r0 + 1);
    rd(acs_pkg::ADDR_STATUS, d, r);
    chk(d[acs_pkg::ST_ABORT_POS], 1'b1);
    // power modes after a conversion, and a start ignored in full shutdown
    wr(acs_pkg::ADDR_CTRL, 32'h00000400, r);
    conv(13);
    chk(power_state, acs_pkg::PWR_SHUT);
    wr(acs_pkg::ADDR_CTRL, 32'h00000800, r);
    conv(13);
    chk(power_state, acs_pkg::PWR_STBY);
    wr(acs_pkg::ADDR_CTRL, 32'h00000C00, r);
    r0 = results;
    i_acs_host_model.convert(13);
    repeat (3) @(posedge aclk);
    chk(power_state, acs_pkg::PWR_SHUT);
    chk(results, r0);
    wr(acs_pkg::ADDR_CTRL, 32'h00000000, r);
    conv(13);
    chk(power_state, acs_pkg::PWR_ON);
    // refused accesses
    rd(4'hC, d, r);
    chk(r, acs_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    wr(acs_pkg::ADDR_STATUS, 32'h00000FFF, r);
    chk(r, acs_pkg::RESP_SLVERR);
    stop_test();
  end
endmodule : adc_channel_sequencer_tb_top
